// >>> rtl/async_serial_receive_status.sv
`timescale 1ns/1ps
`include "async_serial_params.svh"
// Functional notes
// [R1] Transmit data register is read/write; reading never disturbs transmission.
// [R2] Hidden shift register assembles serial bits, moves byte on when room exists.
// [R3] Bytes enter four-deep FIFO; channel 0/1 data port returns oldest.
// [R4] Shifting continues while FIFO full; overrun only when byte cannot move.
// [R5] Parallel four-entry status FIFO; flags show oldest character's status.
// [R6] Multiproc format with filter on: only marker-bit bytes affect flags.
// [R7] Filter ignored without multiproc format; filter off passes every byte.
// [R8] Wake-up filter enable resets to zero.
// [R9] Receive/transmit enables at bits 6/5; transmit disable aborts, keeps empty flag.
// [R10] Transmit enable cleared by reset and peripheral halt mode.
// [R11] Receive-full flag bit 7 sets when byte loads into empty FIFO.
// [R12] Bytes with framing or parity errors still stored and set full.
// [R13] Full clears when FIFO empties, halt, reset, or carrier negated.
// [R14] Overrun bit 6 shows when last good character becomes oldest.
// [R15] Writing one to error reset clears overrun; also halt, reset, carrier.
// [R16] Parity mismatch sets parity error bit 5 when character is oldest.
// [R17] Zero stop bit sets framing error bit 4 when oldest; error reset clears.
// [R18] Carrier detect negated holds channel receiver in reset unless disabled.
// [R19] Reading data port pops data and status FIFOs together.
// [R20] Byte arriving while shift register still full is dropped; overrun flagged.
module async_serial_receive_status #(
  parameter int FIFO_DEPTH = 4,
  parameter logic [15:0] BIT_CLKS = `ASR_BIT_CLKS
) (
  // Clock and reset
  input wire logic CLK_I,
  input wire logic NRST_I,
  // Register port
  input wire logic [7:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  // Line and modem
  input wire logic SERIAL_INPUT_PIN_I,
  input wire logic CARRIER_DETECT_INPUT_N_I,
  input wire logic PERIPHERAL_HALT_MODE_I,
  // Status out
  output logic RX_ENABLE_O,
  output logic TX_ENABLE_O
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] ctrl_a_r, ctrl_a_nxt, ctrl_b_r, ctrl_b_nxt, ext_r, ext_nxt;
  logic [7:0] tx_data_r, tx_data_nxt;
  logic tx_empty_r, tx_empty_nxt;
  logic wr_ca, wr_cb, wr_ext, wr_tx, rd_rx, efr_wr, rx_hold;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
    hit = (a == off);
  endfunction : hit

  assign wr_ca = WR_I && hit(ADDR_I, `ASR_CTRL_A_OFF);
  assign wr_cb = WR_I && hit(ADDR_I, `ASR_CTRL_B_OFF);
  assign wr_ext = WR_I && hit(ADDR_I, `ASR_EXT_OFF);
  assign wr_tx = WR_I && hit(ADDR_I, `ASR_TX_DATA_OFF);
  // Both channel ports map to this channel's FIFO
  assign rd_rx = RD_I && (hit(ADDR_I, `ASR_RX_DATA_CH0_OFF) ||
                          hit(ADDR_I, `ASR_RX_DATA_CH1_OFF)); // R3
  assign efr_wr = wr_ca && WDATA_I[`ASR_CA_EFR_BIT]; // R15
  // Carrier negated or halt acts as receiver reset
  assign rx_hold = PERIPHERAL_HALT_MODE_I ||
                   (!ext_r[`ASR_EXT_CDDIS_BIT] && CARRIER_DETECT_INPUT_N_I); // R18

  always_comb
  begin
    ctrl_a_nxt = ctrl_a_r;
    ctrl_b_nxt = ctrl_b_r;
    ext_nxt = ext_r;
    tx_data_nxt = tx_data_r;
    tx_empty_nxt = tx_empty_r;
    if (wr_ca)
      ctrl_a_nxt = WDATA_I & ~(8'h01 << `ASR_CA_EFR_BIT);
    if (wr_cb)
      ctrl_b_nxt = WDATA_I;
    if (wr_ext)
      ext_nxt = WDATA_I;
    if (wr_tx)
    begin
      tx_data_nxt = WDATA_I;
      tx_empty_nxt = 1'b0;
    end
    // Disabling transmit leaves the empty flag untouched
    if (PERIPHERAL_HALT_MODE_I)
      ctrl_a_nxt[`ASR_CA_TXEN_BIT] = 1'b0; // R10 R9
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      ctrl_a_r <= `ASR_CTRL_A_RST; // R8 R10
      ctrl_b_r <= `ASR_CTRL_B_RST;
      ext_r <= `ASR_EXT_RST;
      tx_data_r <= 8'h00;
      tx_empty_r <= 1'b1;
    end
    else
    begin
      ctrl_a_r <= ctrl_a_nxt;
      ctrl_b_r <= ctrl_b_nxt;
      ext_r <= ext_nxt;
      tx_data_r <= tx_data_nxt;
      tx_empty_r <= tx_empty_nxt;
    end
  end

  assign RX_ENABLE_O = ctrl_a_r[`ASR_CA_RXEN_BIT]; // R9
  assign TX_ENABLE_O = ctrl_a_r[`ASR_CA_TXEN_BIT]; // R9

  ////////////////////////////////////////////////////////////////////////////
  // Receive shifter, mid-bit sampling
  async_serial_pkg::rx_state_t st_r, st_nxt;
  logic [15:0] tick_r, tick_nxt;
  logic [3:0] bit_r, bit_nxt;
  logic [8:0] sh_r, sh_nxt;
  logic [3:0] nbits;
  logic done, stop_ok, par_bit, mpsel, mark, par_en;
  logic held_r, held_nxt, ovr_pend_r, ovr_pend_nxt;
  logic [7:0] held_d_r, held_d_nxt;
  logic held_pe_r, held_pe_nxt, held_fe_r, held_fe_nxt, held_ok_r, held_ok_nxt;

  assign mpsel = ctrl_b_r[`ASR_CB_MPSEL_BIT];
  assign par_en = ctrl_a_r[`ASR_CA_MOD1_BIT];
  // 8 data bits, plus parity or marker bit when selected
  assign nbits = (par_en || mpsel) ? 4'd9 : 4'd8;

  always_comb
  begin
    st_nxt = st_r;
    tick_nxt = (tick_r == 16'h0000) ? 16'h0000 : 16'(tick_r - 1'b1);
    bit_nxt = bit_r;
    sh_nxt = sh_r;
    done = 1'b0;
    stop_ok = 1'b0;
    case (st_r)
      async_serial_pkg::RX_IDLE:
        if (!SERIAL_INPUT_PIN_I && ctrl_a_r[`ASR_CA_RXEN_BIT])
        begin
          st_nxt = async_serial_pkg::RX_START;
          // Reloads are one short: the zero count itself takes a clock
          tick_nxt = 16'((BIT_CLKS >> 1) - 16'h0001);
        end
      async_serial_pkg::RX_START:
        if (tick_r == 16'h0000)
        begin
          st_nxt = SERIAL_INPUT_PIN_I ? async_serial_pkg::RX_IDLE
                                      : async_serial_pkg::RX_DATA;
          tick_nxt = 16'(BIT_CLKS - 16'h0001);
          bit_nxt = 4'd0;
        end
      async_serial_pkg::RX_DATA:
        if (tick_r == 16'h0000)
        begin
          sh_nxt = {SERIAL_INPUT_PIN_I, sh_r[8:1]}; // R2
          bit_nxt = 4'(bit_r + 1'b1);
          tick_nxt = 16'(BIT_CLKS - 16'h0001);
          if (4'(bit_r + 1'b1) == nbits)
            st_nxt = async_serial_pkg::RX_STOP;
        end
      async_serial_pkg::RX_STOP:
        if (tick_r == 16'h0000)
        begin
          done = 1'b1;
          stop_ok = SERIAL_INPUT_PIN_I;
          st_nxt = async_serial_pkg::RX_IDLE;
        end
      default:
        st_nxt = async_serial_pkg::RX_IDLE;
    endcase
    if (nbits == 4'd8 && st_nxt == async_serial_pkg::RX_STOP && st_r == async_serial_pkg::RX_DATA)
      sh_nxt = {1'b0, SERIAL_INPUT_PIN_I, sh_r[8:2]};
  end

  // Aligned frame fields
  logic [7:0] rx_byte;
  assign rx_byte = sh_r[7:0];
  assign par_bit = sh_r[8];
  assign mark = sh_r[8];

  ////////////////////////////////////////////////////////////////////////////
  // Hand-off into the FIFOs
  logic fifo_empty, fifo_full, push, pe_now, accept;
  logic [11:0] fifo_din, fifo_dout;
  async_serial_pkg::rx_status_t in_st, top_st;

  assign pe_now = par_en && ((^rx_byte) ^ par_bit ^ ctrl_b_r[`ASR_CB_PSENSE_BIT]); // R16
  // Filter only meaningful in multiproc format
  assign accept = !(mpsel && ctrl_a_r[`ASR_CA_WAKE_BIT]) || mark; // R6 R7
  assign push = held_r && !fifo_full; // R2 R4
  assign in_st = '{overrun_flag: ovr_pend_r, perr: held_pe_r, ferr: held_fe_r,
                  brk: held_fe_r && (held_d_r == 8'h00)};
  assign fifo_din = {in_st, held_d_r}; // R5 R12

  always_comb
  begin
    held_nxt = held_r;
    held_d_nxt = held_d_r;
    held_pe_nxt = held_pe_r;
    held_fe_nxt = held_fe_r;
    held_ok_nxt = held_ok_r;
    ovr_pend_nxt = ovr_pend_r;
    if (push)
    begin
      held_nxt = 1'b0;
      ovr_pend_nxt = 1'b0;
    end
    if (done && accept)
    begin
      if (held_r && !push)
        ovr_pend_nxt = 1'b1; // R20 R4 R14
      else
      begin
        held_nxt = 1'b1;
        held_d_nxt = rx_byte;
        held_pe_nxt = pe_now;
        held_fe_nxt = !stop_ok; // R17
        held_ok_nxt = 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
    begin
      st_r <= async_serial_pkg::RX_IDLE;
      tick_r <= 16'h0000;
      bit_r <= 4'd0;
      sh_r <= 9'h000;
      held_r <= 1'b0;
      held_d_r <= 8'h00;
      held_pe_r <= 1'b0;
      held_fe_r <= 1'b0;
      held_ok_r <= 1'b0;
      ovr_pend_r <= 1'b0;
    end
    else if (rx_hold)
    begin
      st_r <= async_serial_pkg::RX_IDLE; // R18
      held_r <= 1'b0;
      ovr_pend_r <= 1'b0;
    end
    else
    begin
      st_r <= st_nxt;
      tick_r <= tick_nxt;
      bit_r <= bit_nxt;
      sh_r <= sh_nxt;
      held_r <= held_nxt;
      held_d_r <= held_d_nxt;
      held_pe_r <= held_pe_nxt;
      held_fe_r <= held_fe_nxt;
      held_ok_r <= held_ok_nxt;
      ovr_pend_r <= ovr_pend_nxt;
    end
  end

  rx_fifo #(
    .WIDTH(12),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .clr_i(rx_hold),
    .push_i(push),
    .din_i(fifo_din),
    .pop_i(rd_rx), // R19
    .dout_o(fifo_dout),
    .empty_o(fifo_empty),
    .full_o(fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Sticky error flags, loaded from the oldest entry
  logic [3:0] err_r, err_nxt;
  assign top_st = async_serial_pkg::rx_status_t'(fifo_dout[11:8]);

  always_comb
  begin
    err_nxt = err_r;
    if (efr_wr)
      err_nxt = 4'h0; // R15 R17
    // Set beats clear in the same cycle
    if (!fifo_empty)
      err_nxt = err_nxt | top_st; // R5 R14 R16 R17
  end

  always_ff @(posedge CLK_I or negedge NRST_I)
  begin
    if (!NRST_I)
      err_r <= 4'h0;
    else if (rx_hold)
      err_r <= 4'h0; // R15
    else
      err_r <= err_nxt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  logic [7:0] flags;
  always_comb
  begin
    flags = 8'h00;
    flags[`ASR_FL_FULL_BIT] = !fifo_empty; // R11 R13
    flags[`ASR_FL_OVERRUN_FLAG_BIT] = err_r[3];
    flags[`ASR_FL_PERR_BIT] = err_r[2];
    flags[`ASR_FL_FERR_BIT] = err_r[1];
    flags[`ASR_FL_BRK_BIT] = err_r[0];
    flags[`ASR_FL_TXE_BIT] = tx_empty_r;
    RDATA_O = 8'h00;
    if (rd_rx)
      RDATA_O = fifo_empty ? 8'h00 : fifo_dout[7:0]; // R3
    else if (hit(ADDR_I, `ASR_FLAGS_OFF))
      RDATA_O = flags;
    else if (hit(ADDR_I, `ASR_CTRL_A_OFF))
      RDATA_O = ctrl_a_r;
    else if (hit(ADDR_I, `ASR_CTRL_B_OFF))
      RDATA_O = ctrl_b_r;
    else if (hit(ADDR_I, `ASR_EXT_OFF))
      RDATA_O = ext_r;
    else if (hit(ADDR_I, `ASR_TX_DATA_OFF))
      RDATA_O = tx_data_r; // R1
  end

  ////////////////////////////////////////////////////////////////////////////
  a_halt_txen: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    PERIPHERAL_HALT_MODE_I |=> !TX_ENABLE_O) else $error("tx enable survived halt"); // R10
  a_push_full: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    push && fifo_empty && !rx_hold |=> flags[7]) else $error("full flag not set"); // R11
  a_hold_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    rx_hold |=> fifo_empty && err_r == 4'h0) else $error("hold did not clear"); // R13
  a_efr_clear: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    efr_wr && fifo_empty && !rx_hold |=> err_r == 4'h0) else $error("error reset failed"); // R15
  a_tx_read: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    RD_I && !WR_I |=> $stable(tx_data_r) && $stable(tx_empty_r)) else $error("read changed tx"); // R1
  a_drop_new: assert property (@(posedge CLK_I) disable iff (!NRST_I || rx_hold)
    done && accept && held_r && !push |=> held_r && $stable(held_d_r) && ovr_pend_r)
    else $error("new byte not dropped"); // R20
  a_filter: assert property (@(posedge CLK_I) disable iff (!NRST_I || rx_hold)
    done && !accept && !held_r |=> !held_r) else $error("filtered byte taken"); // R6
  a_overrun_flag_show: assert property (@(posedge CLK_I) disable iff (!NRST_I)
    !fifo_empty && top_st.overrun_flag && !rx_hold |=> err_r[3]) else $error("overrun not shown"); // R14
endmodule : async_serial_receive_status

// >>> rtl/async_serial_params.svh
`ifndef ASYNC_SERIAL_PARAMS_SVH
`define ASYNC_SERIAL_PARAMS_SVH
// Register offsets
`define ASR_RX_DATA_CH0_OFF 8'h08
`define ASR_RX_DATA_CH1_OFF 8'h09
`define ASR_CTRL_A_OFF 8'h00
`define ASR_CTRL_B_OFF 8'h02
`define ASR_FLAGS_OFF 8'h04
`define ASR_TX_DATA_OFF 8'h06
`define ASR_EXT_OFF 8'h12
// Control A fields
`define ASR_CA_WAKE_BIT 7
`define ASR_CA_RXEN_BIT 6
`define ASR_CA_TXEN_BIT 5
`define ASR_CA_EFR_BIT 3
`define ASR_CA_MOD2_BIT 2
`define ASR_CA_MOD1_BIT 1
// Control B fields
`define ASR_CB_MPSEL_BIT 6
`define ASR_CB_PSENSE_BIT 4
// Extension fields
`define ASR_EXT_CDDIS_BIT 6
// Flags fields
`define ASR_FL_FULL_BIT 7
`define ASR_FL_OVERRUN_FLAG_BIT 6
`define ASR_FL_PERR_BIT 5
`define ASR_FL_FERR_BIT 4
`define ASR_FL_BRK_BIT 3
`define ASR_FL_TXE_BIT 1
// Reset values
`define ASR_CTRL_A_RST 8'h00
`define ASR_CTRL_B_RST 8'h00
`define ASR_EXT_RST 8'h00
// Timing: bit time in system clocks
`define ASR_BIT_CLKS 16'h0010
`endif

// >>> rtl/async_serial_pkg.sv
package async_serial_pkg;
  typedef enum logic [1:0]
  {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } rx_state_t;
  typedef struct packed
  {
    logic overrun_flag;
    logic perr;
    logic ferr;
    logic brk;
  } rx_status_t;
endpackage : async_serial_pkg

// >>> rtl/rx_fifo.sv
`timescale 1ns/1ps
module rx_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic clr_i,
  input wire logic push_i,
  input wire logic [WIDTH-1:0] din_i,
  input wire logic pop_i,
  output logic [WIDTH-1:0] dout_o,
  output logic empty_o,
  output logic full_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [AW:0] cnt_r, cnt_nxt;
  logic do_push, do_pop;

  assign do_pop = pop_i && (cnt_r != '0);
  assign do_push = push_i && (cnt_r != (AW+1)'(DEPTH));
  assign empty_o = (cnt_r == '0);
  assign full_o = (cnt_r == (AW+1)'(DEPTH));
  assign dout_o = mem_r[rp_r];

  always_comb
  begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (clr_i)
    begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end
    else
    begin
      if (do_push)
        wp_nxt = (wp_r == AW'(DEPTH-1)) ? '0 : AW'(wp_r + 1'b1);
      if (do_pop)
        rp_nxt = (rp_r == AW'(DEPTH-1)) ? '0 : AW'(rp_r + 1'b1);
      cnt_nxt = (AW+1)'(cnt_r + {AW'(0), do_push} - {AW'(0), do_pop});
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // Storage needs no reset; occupancy gates every read
  always_ff @(posedge clk_i)
  begin
    if (do_push && !clr_i)
      mem_r[wp_r] <= din_i;
  end
endmodule : rx_fifo

// >>> testbench/serial_remote.sv
`timescale 1ns/1ps
module serial_remote #(
  parameter int BIT_CLKS = 4
) (
  // Clock
  input wire logic clk_i,
  // Line
  output logic line_o
);
  // Line rests high between frames, as a real sender leaves it
  initial line_o = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Start, 8 data LSB first, optional ninth bit, stop; caller enters after posedge
  task automatic send(input logic [7:0] data, input logic has9, input logic bit9,
                      input logic stop);
    int i;
    logic v;
    begin
      for (i = 0; i < 11; i++)
      begin
        v = (i == 0) ? 1'b0 : (i < 9) ? data[i-1] : (i == 9) ? bit9 : stop;
        if (i != 9 || has9)
        begin
          line_o <= v;
          repeat (BIT_CLKS) @(posedge clk_i);
        end
      end
      line_o <= 1'b1;
      // Two idle bit times so the byte lands before the next frame
      repeat (2 * BIT_CLKS) @(posedge clk_i);
    end
  endtask : send
endmodule : serial_remote

// >>> testbench/tb_top.sv
`timescale 1ns/1ps
`include "async_serial_params.svh"
module tb_top;
  localparam logic [7:0] CA = `ASR_CTRL_A_OFF;
  localparam logic [7:0] CB = `ASR_CTRL_B_OFF;
  localparam logic [7:0] FL = `ASR_FLAGS_OFF;
  localparam logic [7:0] TX = `ASR_TX_DATA_OFF;
  localparam logic [7:0] EX = `ASR_EXT_OFF;
  localparam logic [7:0] D0 = `ASR_RX_DATA_CH0_OFF;
  localparam logic [7:0] D1 = `ASR_RX_DATA_CH1_OFF;
  logic clk, nrst, wr, rd, line, cd_n, halt, rx_en, tx_en;
  logic [7:0] addr, wdata, rdata;
  int num_errors = 0;
  int n_checks = 0;

  always #50 clk = ~clk;

  async_serial_receive_status #(.FIFO_DEPTH(4), .BIT_CLKS(16'h0004)) i_dut (
    .CLK_I(clk), .NRST_I(nrst), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
    .RD_I(rd), .RDATA_O(rdata), .SERIAL_INPUT_PIN_I(line),
    .CARRIER_DETECT_INPUT_N_I(cd_n), .PERIPHERAL_HALT_MODE_I(halt),
    .RX_ENABLE_O(rx_en), .TX_ENABLE_O(tx_en));

  serial_remote #(.BIT_CLKS(4)) i_remote (.clk_i(clk), .line_o(line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    begin
      if (num_errors == 0 && n_checks > 0)
        $display("Test passed");
      else
        $display("Test failed");
      $finish;
    end
  endtask : complete_run

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    begin
      n_checks++;
      if (seen !== exp)
      begin
        num_errors++;
        $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
    end
  endtask : check

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      @(posedge clk);
    end
  endtask : wr_reg

  // Read strobe on data ports pops one entry
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    begin
      addr <= a;
      rd <= 1'b1;
      @(negedge clk);
      d = rdata;
      @(posedge clk);
      rd <= 1'b0;
      @(posedge clk);
    end
  endtask : rd_reg

  task automatic chk_reg(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    begin
      rd_reg(a, d);
      check($sformatf("reg %h", a), d, e);
    end
  endtask : chk_reg

  task automatic wait_full;
    int i;
    begin
      for (i = 0; i < 100; i++)
      begin
        addr <= FL;
        @(negedge clk);
        if (rdata[7] === 1'b1)
          break;
        @(posedge clk);
      end
      @(posedge clk);
      if (i == 100)
      begin
        num_errors++;
        complete_run();
      end
    end
  endtask : wait_full

  ////////////////////////////////////////////////////////////////////////////
  task automatic s_reset;
    begin
      chk_reg(CA, 8'h00);
      chk_reg(FL, 8'h02);
      check("tx_en", {7'h00, tx_en}, 8'h00);
      wr_reg(8'h3F, 8'hFF);
      chk_reg(8'h3F, 8'h00);
      wr_reg(CA, 8'h40);
      check("rx_en", {7'h00, rx_en}, 8'h01);
      check("tx_en", {7'h00, tx_en}, 8'h00);
      wr_reg(CA, 8'h20);
      check("rx_en", {7'h00, rx_en}, 8'h00);
      check("tx_en", {7'h00, tx_en}, 8'h01);
      wr_reg(CA, 8'h60);
    end
  endtask : s_reset

  task automatic s_single;
    begin
      i_remote.send(8'hA5, 1'b0, 1'b0, 1'b1);
      wait_full();
      chk_reg(FL, 8'h82);
      chk_reg(D0, 8'hA5);
      chk_reg(FL, 8'h02);
    end
  endtask : s_single

  // Four fill the FIFO, fifth waits in the shifter, sixth is lost
  task automatic s_fifo;
    begin
      i_remote.send(8'h11, 1'b0, 1'b0, 1'b1);
      i_remote.send(8'h22, 1'b0, 1'b0, 1'b1);
      i_remote.send(8'h33, 1'b0, 1'b0, 1'b1);
      i_remote.send(8'h44, 1'b0, 1'b0, 1'b1);
      i_remote.send(8'h55, 1'b0, 1'b0, 1'b1);
      i_remote.send(8'h66, 1'b0, 1'b0, 1'b1);
      chk_reg(FL, 8'h82);
      chk_reg(D0, 8'h11);
      chk_reg(D1, 8'h22);
      chk_reg(D0, 8'h33);
      chk_reg(D1, 8'h44);
      wait_full();
      chk_reg(FL, 8'hC2);
      chk_reg(D0, 8'h55);
      chk_reg(FL, 8'h42);
      wr_reg(CA, 8'h68);
      chk_reg(FL, 8'h02);
    end
  endtask : s_fifo

  task automatic s_errors;
    logic [7:0] p0, p1, d;
    begin
      wr_reg(CA, 8'h62);
      i_remote.send(8'h0F, 1'b1, 1'b0, 1'b1);
      wait_full();
      rd_reg(FL, p0);
      rd_reg(D0, d);
      wr_reg(CA, 8'h6A);
      i_remote.send(8'h0F, 1'b1, 1'b1, 1'b1);
      wait_full();
      rd_reg(FL, p1);
      rd_reg(D0, d);
      // Error reset too, so the sticky parity flag is gone before the framing case
      wr_reg(CA, 8'h68);
      // Exactly one of the two parity values must mismatch
      check("perr", {7'h00, p0[5] ^ p1[5]}, 8'h01);
      i_remote.send(8'h3C, 1'b0, 1'b0, 1'b0);
      wait_full();
      chk_reg(FL, 8'h92);
      chk_reg(D0, 8'h3C);
      wr_reg(CA, 8'h68);
      chk_reg(FL, 8'h02);
    end
  endtask : s_errors

  task automatic s_wake;
    begin
      wr_reg(CB, 8'h40);
      wr_reg(CA, 8'hE0);
      i_remote.send(8'h5A, 1'b1, 1'b0, 1'b1);
      chk_reg(FL, 8'h02);
      i_remote.send(8'h5B, 1'b1, 1'b1, 1'b1);
      wait_full();
      chk_reg(D0, 8'h5B);
      wr_reg(CA, 8'h60);
      i_remote.send(8'h5C, 1'b1, 1'b0, 1'b1);
      wait_full();
      chk_reg(D0, 8'h5C);
      wr_reg(CB, 8'h00);
      wr_reg(CA, 8'hE0);
      i_remote.send(8'h5D, 1'b0, 1'b0, 1'b1);
      wait_full();
      chk_reg(D1, 8'h5D);
      wr_reg(CA, 8'h60);
    end
  endtask : s_wake

  task automatic s_carrier;
    begin
      i_remote.send(8'h77, 1'b0, 1'b0, 1'b1);
      wait_full();
      cd_n <= 1'b1;
      repeat (2) @(posedge clk);
      chk_reg(FL, 8'h02);
      i_remote.send(8'h78, 1'b0, 1'b0, 1'b1);
      chk_reg(FL, 8'h02);
      wr_reg(EX, 8'h40);
      i_remote.send(8'h79, 1'b0, 1'b0, 1'b1);
      wait_full();
      chk_reg(D0, 8'h79);
      cd_n <= 1'b0;
      wr_reg(EX, 8'h00);
    end
  endtask : s_carrier

  task automatic s_halt;
    logic [7:0] d;
    begin
      i_remote.send(8'h81, 1'b0, 1'b0, 1'b1);
      wait_full();
      halt <= 1'b1;
      repeat (2) @(posedge clk);
      check("tx_en", {7'h00, tx_en}, 8'h00);
      rd_reg(FL, d);
      check("flags", d & 8'hF0, 8'h00);
      halt <= 1'b0;
      chk_reg(D0, 8'h00);
    end
  endtask : s_halt

  // Transmit register reads back and reading leaves it alone
  task automatic s_txdata;
    begin
      wr_reg(CA, 8'h60);
      wr_reg(TX, 8'h3C);
      chk_reg(TX, 8'h3C);
      chk_reg(TX, 8'h3C);
      chk_reg(FL, 8'h00);
      wr_reg(CA, 8'h40);
      chk_reg(FL, 8'h00);
    end
  endtask : s_txdata

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk = 1'b0;
    nrst = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    cd_n = 1'b0;
    halt = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    s_reset();
    s_single();
    s_fifo();
    s_errors();
    s_wake();
    s_carrier();
    s_halt();
    s_txdata();
    complete_run();
  end
endmodule : tb_top
